/* File: design/pgd_top.sv */
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pgd_top
  import pgd_pkg::*;
#(
  parameter int ADDR_W       = 12,
  parameter int LATCH_PERIOD = LATCH_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              tx_bit_en,
  output logic                   tx_bit,
  input  wire logic              rx_bit_en,
  input  wire logic              rx_bit,
  output logic                   irq_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0]        ctrl_q;
  logic [2:0]        ien_q;
  logic [4:0]        len_q;
  logic [4:0]        tap_q;
  logic [3:0]        eins_q;
  logic              ple_q;
  logic [31:0]       pi_q;
  logic [31:0]       pd_q;
  logic              chg_flag_q;
  logic              be_flag_q;
  logic              upd_flag_q;
  logic              ovr_flag_q;
  logic              sync_ok;
  logic              aw_got_q;
  logic              w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wbyte_q;
  logic              wlane_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  logic       do_write;
  logic       rd_take;
  logic [6:0] widx;
  logic [6:0] ridx;
  logic       whit;
  logic       rhit;
  logic       wr_en;
  logic       rd_status;
  logic [7:0] rbyte;

  // Index of a byte address, plus a legality check
  function automatic logic idx_ok(input logic [ADDR_W-1:0] a);
    logic [6:0] i;
    i = a[8:2];
    idx_ok = (a >> 9) == '0 && i >= IDX_CTRL && i != 7'h77;
  endfunction : idx_ok

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  // Address and data are caught separately, in either order
  assign s_axi_awready = ~aw_got_q;
  assign s_axi_wready  = ~w_got_q;
  assign do_write      = aw_got_q & w_got_q & ~bvalid_q;
  assign widx          = awaddr_q[8:2];
  assign whit          = idx_ok(awaddr_q);
  assign wr_en         = do_write & whit & wlane_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wbyte_q  <= 8'h00;
      wlane_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_got_q) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_q) begin
        w_got_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= whit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read answers one cycle after the address is taken
  assign s_axi_arready = ~rvalid_q;
  assign rd_take       = s_axi_arvalid & ~rvalid_q;
  assign ridx          = s_axi_araddr[8:2];
  assign rhit          = idx_ok(s_axi_araddr);
  assign rd_status     = rd_take & rhit & (ridx == IDX_IRQ);
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    rbyte = 8'h00;
    case (ridx)
      IDX_CTRL: rbyte = ctrl_q;
      IDX_IRQ:  rbyte = {ien_q, sync_ok, chg_flag_q, be_flag_q,
                         upd_flag_q, ovr_flag_q};
      IDX_LEN:  rbyte = {3'h0, len_q};
      IDX_TAP:  rbyte = {3'h0, tap_q};
      IDX_EINS: rbyte = {4'h0, eins_q};
      IDX_AUX:  rbyte = {7'h00, ple_q};
      default: begin
        if (ridx >= IDX_PI0 && ridx <= IDX_PI3) begin
          rbyte = pi_q[8*ridx[1:0] +: 8];
        end else if (ridx >= IDX_PD0) begin
          rbyte = pd_q[8*ridx[1:0] +: 8];
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rhit ? {24'h000000, rbyte} : 32'h00000000;
      rresp_q  <= rhit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      ien_q  <= 3'h0;
      len_q  <= 5'h00;
      tap_q  <= 5'h00;
      eins_q <= 4'h0;
      ple_q  <= 1'b0;
    end else if (wr_en) begin
      case (widx)
        IDX_CTRL: ctrl_q <= wbyte_q & CTRL_MASK;
        IDX_IRQ:  ien_q  <= wbyte_q[IE_SYNC:IE_UPD];
        IDX_LEN:  len_q  <= wbyte_q[4:0];
        IDX_TAP:  tap_q  <= wbyte_q[4:0];
        IDX_EINS: eins_q <= wbyte_q[3:0];
        IDX_AUX:  ple_q  <= wbyte_q[AUX_PLE];
        default: ;
      endcase
    end
  end

  // One insert byte per entry
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pi
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pi_q[8*gi +: 8] <= 8'h00;
        end else if (wr_en && widx == IDX_PI0 + 7'(gi)) begin
          pi_q[8*gi +: 8] <= wbyte_q;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Generator and error insertion

  logic        repetitive;
  logic        gen_bit;
  logic        gen_load;
  logic        ev_prev_q;
  logic        single_pend_q;
  logic [23:0] rate_cnt_q;
  logic [23:0] rate_period;
  logic        rate_hit;

  assign repetitive = ctrl_q[CTRL_SEL];
  // Top insert byte commits the seed or pattern
  assign gen_load   = wr_en & (widx == IDX_PI3);

  pgd_seq_engine u_gen (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .load       (gen_load),
    .seed       (pi_q),
    .step       (tx_bit_en),
    .force_en   (1'b0),
    .force_bit  (1'b0),
    .len        (len_q),
    .tap        (tap_q),
    .repetitive (repetitive),
    .next_bit   (gen_bit)
  );

  // Rate table; lowest codes insert nothing
  always_comb begin
    rate_period = '0;
    case (eins_q[2:0])
      3'h2:    rate_period = RATE_E2;
      3'h3:    rate_period = RATE_E3;
      3'h4:    rate_period = RATE_E4;
      3'h5:    rate_period = RATE_E5;
      3'h6:    rate_period = RATE_E6;
      3'h7:    rate_period = RATE_E7;
      default: rate_period = '0;
    endcase
  end

  assign rate_hit = rate_period != '0 && rate_cnt_q >= rate_period - 24'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_cnt_q <= '0;
    end else if (rate_period == '0) begin
      rate_cnt_q <= '0;
    end else if (tx_bit_en) begin
      rate_cnt_q <= rate_hit ? '0 : rate_cnt_q + 24'h1;
    end
  end

  // Single error pends until the next transmitted bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_prev_q     <= 1'b0;
      single_pend_q <= 1'b0;
    end else begin
      ev_prev_q <= eins_q[EINS_EVENT];
      if (eins_q[EINS_EVENT] && !ev_prev_q) begin
        single_pend_q <= 1'b1;
      end else if (tx_bit_en) begin
        single_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_bit <= 1'b0;
    end else if (tx_bit_en) begin
      tx_bit <= gen_bit ^ ctrl_q[CTRL_TRANSMIT_INVERT]
                ^ single_pend_q ^ rate_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detector

  pgd_sync_type state_q;
  logic         rx_d;
  logic         det_bit;
  logic         searching;
  logic         checking;
  logic         bit_err;
  logic         man_prev_q;
  logic         resync;
  logic [4:0]   fill_q;
  logic [5:0]   clean_q;
  logic [SYNC_WIN-1:0] hist_q;
  logic [5:0]   win_q;
  logic [5:0]   win_d;
  logic         loss;

  assign rx_d      = rx_bit ^ ctrl_q[CTRL_RECEIVE_INVERT];
  assign searching = state_q == SYNC_SEARCH;
  assign checking  = state_q == SYNC_VERIFY || state_q == SYNC_LOCKED;
  assign sync_ok   = state_q == SYNC_LOCKED;

  // Reference runs the same settings; fed raw bits while searching
  pgd_seq_engine u_ref (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .load       (1'b0),
    .seed       (32'h00000000),
    .step       (rx_bit_en),
    .force_en   (searching),
    .force_bit  (rx_d),
    .len        (len_q),
    .tap        (tap_q),
    .repetitive (repetitive),
    .next_bit   (det_bit)
  );

  assign bit_err = rx_bit_en & checking & (rx_d != det_bit);

  // Sliding window of error marks while locked
  assign win_d = win_q + {5'h00, bit_err} - {5'h00, hist_q[SYNC_WIN-1]};
  assign loss  = rx_bit_en & sync_ok & (win_d >= LOSS_ERRS);

  always_ff @(posedge aclk) begin
    if (!aresetn || !sync_ok) begin
      hist_q <= '0;
      win_q  <= '0;
    end else if (rx_bit_en) begin
      hist_q <= {hist_q[SYNC_WIN-2:0], bit_err};
      win_q  <= win_d;
    end
  end

  // Only a rising edge of the manual bit restarts
  assign resync = ctrl_q[CTRL_MAN] & ~man_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      man_prev_q <= 1'b0;
    end else begin
      man_prev_q <= ctrl_q[CTRL_MAN];
    end
  end

  // Acquisition: fill the reference, then demand clean bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= SYNC_SEARCH;
      fill_q  <= 5'h00;
      clean_q <= 6'h00;
    end else if (resync) begin
      state_q <= SYNC_SEARCH;
      fill_q  <= 5'h00;
      clean_q <= 6'h00;
    end else if (rx_bit_en) begin
      case (state_q)
        SYNC_SEARCH: begin
          fill_q <= fill_q + 5'h01;
          if (fill_q == len_q) begin
            state_q <= SYNC_VERIFY;
            fill_q  <= 5'h00;
            clean_q <= 6'h00;
          end
        end
        SYNC_VERIFY: begin
          if (bit_err) begin
            state_q <= SYNC_SEARCH;
          end else if (clean_q == LOCK_BITS - 6'h01) begin
            state_q <= SYNC_LOCKED;
          end else begin
            clean_q <= clean_q + 6'h01;
          end
        end
        SYNC_LOCKED: begin
          if (loss) begin
            // Without auto search, sits out of sync until manual
            state_q <= ctrl_q[CTRL_AUTO] ? SYNC_SEARCH
                                         : SYNC_HALTED;
          end
        end
        SYNC_HALTED: state_q <= SYNC_HALTED;
        default:     state_q <= SYNC_SEARCH;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulators and detector registers

  logic [31:0] rx_shift_q;
  logic [31:0] err_acc_q;
  logic [31:0] bit_acc_q;
  logic [31:0] sec_cnt_q;
  logic        sec_tick;
  logic        latch;
  logic        err_cnt;
  logic        pd_write;

  assign err_cnt  = bit_err & sync_ok;
  assign sec_tick = sec_cnt_q == 32'(LATCH_PERIOD - 1);
  assign pd_write = do_write & whit
                  & (widx >= IDX_PD0 || widx == IDX_GUPD);
  assign latch    = (sec_tick & ple_q) | pd_write;

  always_ff @(posedge aclk) begin
    if (!aresetn || sec_tick) begin
      sec_cnt_q <= '0;
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'h1;
    end
  end

  // Counts restart at each latch, keeping the current bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_shift_q <= '0;
      err_acc_q  <= '0;
      bit_acc_q  <= '0;
    end else begin
      if (rx_bit_en) begin
        rx_shift_q <= {rx_shift_q[30:0], rx_d};
      end
      err_acc_q <= (latch ? '0 : err_acc_q) + {31'h0, err_cnt};
      bit_acc_q <= (latch ? '0 : bit_acc_q) + {31'h0, rx_bit_en};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_q <= '0;
    end else if (latch) begin
      case (ctrl_q[CTRL_FUNC +: 2])
        FUNC_ERR:  pd_q <= err_acc_q;
        FUNC_BITS: pd_q <= bit_acc_q;
        default:   pd_q <= rx_shift_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags and interrupt; a set wins over a read clear

  logic sync_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_prev_q <= 1'b0;
      chg_flag_q  <= 1'b0;
      be_flag_q   <= 1'b0;
      upd_flag_q  <= 1'b0;
      ovr_flag_q  <= 1'b0;
    end else begin
      sync_prev_q <= sync_ok;
      chg_flag_q  <= (sync_ok != sync_prev_q)
                   | (chg_flag_q & ~rd_status);
      be_flag_q   <= err_cnt | (be_flag_q & ~rd_status);
      upd_flag_q  <= latch | (upd_flag_q & ~rd_status);
      ovr_flag_q  <= (latch & upd_flag_q)
                   | (ovr_flag_q & ~rd_status);
    end
  end

  // Active-low output from enabled flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~((ien_q[2] & chg_flag_q)
               | (ien_q[1] & be_flag_q)
               | (ien_q[0] & upd_flag_q));
    end
  end

endmodule : pgd_top

`default_nettype wire

/* File: design/pgd_pkg.sv */
package pgd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_CTRL  = 7'h70;
  localparam logic [6:0] IDX_IRQ   = 7'h71;
  localparam logic [6:0] IDX_LEN   = 7'h72;
  localparam logic [6:0] IDX_TAP   = 7'h73;
  localparam logic [6:0] IDX_EINS  = 7'h74;
  localparam logic [6:0] IDX_AUX   = 7'h75;
  localparam logic [6:0] IDX_GUPD  = 7'h76;
  localparam logic [6:0] IDX_PI0   = 7'h78;
  localparam logic [6:0] IDX_PI3   = 7'h7B;
  localparam logic [6:0] IDX_PD0   = 7'h7C;
  localparam logic [6:0] IDX_PD3   = 7'h7F;

  // Control fields
  localparam int         CTRL_FUNC = 6;
  localparam int         CTRL_SEL  = 4;
  localparam int         CTRL_TRANSMIT_INVERT = 3;
  localparam int         CTRL_RECEIVE_INVERT = 2;
  localparam int         CTRL_AUTO = 1;
  localparam int         CTRL_MAN  = 0;
  localparam logic [7:0] CTRL_RST  = 8'h02;
  localparam logic [7:0] CTRL_MASK = 8'hDF;

  // Enable / status fields
  localparam int IE_SYNC = 7;
  localparam int IE_BE   = 6;
  localparam int IE_UPD  = 5;
  localparam int ST_SYNC = 4;
  localparam int ST_CHG  = 3;
  localparam int ST_BE   = 2;
  localparam int ST_UPD  = 1;
  localparam int ST_OVR  = 0;

  localparam int         EINS_EVENT = 3;
  localparam int         AUX_PLE    = 0;
  localparam logic [1:0] FUNC_ERR   = 2'h2;
  localparam logic [1:0] FUNC_BITS  = 2'h3;

  // Sync criteria
  localparam int         SYNC_WIN  = 48;
  localparam logic [5:0] LOSS_ERRS = 6'h0A;
  localparam logic [5:0] LOCK_BITS = 6'h30;

  // Error rate periods in bits
  localparam logic [23:0] RATE_E2 = 24'h000064;
  localparam logic [23:0] RATE_E3 = 24'h0003E8;
  localparam logic [23:0] RATE_E4 = 24'h002710;
  localparam logic [23:0] RATE_E5 = 24'h0186A0;
  localparam logic [23:0] RATE_E6 = 24'h0F4240;
  localparam logic [23:0] RATE_E7 = 24'h989680;

  // Periodic latch time
  localparam longint CLK_HZ         = 250000000;
  localparam longint LATCH_PERIOD_S = 1;
  localparam int     LATCH_CYCLES   = int'(LATCH_PERIOD_S * CLK_HZ);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    SYNC_SEARCH = 2'b00,
    SYNC_VERIFY = 2'b01,
    SYNC_LOCKED = 2'b10,
    SYNC_HALTED = 2'b11
  } pgd_sync_type;

endpackage : pgd_pkg

/* File: design/pgd_seq_engine.sv */
`timescale 1ns/1ps
`default_nettype none

module pgd_seq_engine (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        load,
  input  wire logic [31:0] seed,
  input  wire logic        step,
  input  wire logic        force_en,
  input  wire logic        force_bit,
  input  wire logic [4:0]  len,
  input  wire logic [4:0]  tap,
  input  wire logic        repetitive,
  output logic             next_bit
);

  logic [31:0] state_q;

  // Oldest bit sits at index len; higher bits are ignored unless tap is above len and repetitive is low
  assign next_bit = repetitive ? state_q[len]
                               : state_q[len] ^ state_q[tap];

  // Shift in own sequence, or forced bits while force_en is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= 32'h00000000;
    end else if (load) begin
      state_q <= seed;
    end else if (step) begin
      state_q <= {state_q[30:0], force_en ? force_bit : next_bit};
    end
  end

endmodule : pgd_seq_engine

`default_nettype wire

/* File: dv/pgd_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module pgd_checker
  import pgd_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              tx_bit_en,
  input wire logic              tx_bit,
  input wire logic              irq_n
);
  // One domain, so clock and reset are given once
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////
  // Write answer two edges after the take
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write answer late");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer late");
  // Read data must not slip while the master stalls
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved");
  // One answer per taken address; a second one would clear flags twice
  property p_ar_block;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read answered twice");
  property p_decerr;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(12'h1DC)
      |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0;
  endproperty
  a_decerr: assert property (p_decerr)
    else $error("unmapped read accepted");
  property p_rd_hi;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("upper read lanes set");
  // Line bit may only move after a slot strobe
  property p_tx_hold;
    !tx_bit_en |=> $stable(tx_bit);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("line bit moved off slot");
  property p_irq_rst;
    $rose(aresetn) |-> irq_n && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_irq_rst: assert property (p_irq_rst)
    else $error("bad state after reset");
endmodule : pgd_checker

bind pgd_top pgd_checker #(.ADDR_W(ADDR_W)) i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .tx_bit_en, .tx_bit, .irq_n
);

`default_nettype wire

/* File: dv/pgd_line_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pgd_line_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  input  wire logic flip,
  input  wire logic tx_bit,
  output logic      tx_bit_en,
  output logic      rx_bit_en,
  output logic      rx_bit
);
  logic [1:0] cnt_q;
  logic       txd_q;

  // Slot every fourth cycle, looped back once tx_bit has moved
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q     <= 2'h0;
      txd_q     <= 1'b0;
      tx_bit_en <= 1'b0;
      rx_bit_en <= 1'b0;
      rx_bit    <= 1'b0;
    end else begin
      cnt_q     <= cnt_q + 2'h1;
      tx_bit_en <= run && cnt_q == 2'h0;
      txd_q     <= tx_bit_en;
      rx_bit_en <= txd_q;
      // Off-slot data toggles so a stray sample cannot match
      rx_bit    <= txd_q ? tx_bit ^ flip : ~rx_bit;
    end
  end
endmodule : pgd_line_model

`default_nettype wire

/* File: dv/test_pattern_gen_detect.sv */
`timescale 1ns/1ps
`default_nettype none

module test_pattern_gen_detect
  import pgd_pkg::*;
;
  logic        aclk;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        run = 1'b0, flip = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [1:0]  bresp;
  logic        txe, tx_bit, rxe, rx_bit, irq_n;
  logic [15:0] p;
  logic [7:0]  v;
  int          n_errors = 0, compares = 0;

  pgd_top #(.LATCH_PERIOD(200)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tx_bit_en(txe), .tx_bit, .rx_bit_en(rxe),
    .rx_bit, .irq_n
  );
  pgd_line_model i_line (
    .aclk, .aresetn, .run, .flip, .tx_bit, .tx_bit_en(txe),
    .rx_bit_en(rxe), .rx_bit
  );

  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // Channels offered together, each dropped when taken
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awaddr  <= {3'h0, idx, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!bvalid);
    check({6'h00, bresp}, {6'h00, RESP_OKAY});
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] idx, output logic [7:0] d);
    @(posedge aclk);
    araddr  <= {3'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata[7:0];
    rready <= 1'b0;
  endtask : rd

  ////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      rd(IDX_CTRL + 7'(i), v);
      check(v, i == 0 ? CTRL_RST : 8'h00);
    end
    rd(IDX_AUX + 7'h02, v);
    check(v, 8'h00);
    $display("reset done");
  endtask : t_reset

  // Generator reloads only while the line is idle
  task automatic t_tx;
    for (int i = 0; i < 2; i++) begin
      run <= 1'b0;
      wr(IDX_CTRL, {4'h1, i[0], 3'h2});
      wr(IDX_LEN, 8'h07);
      wr(IDX_PI0, 8'hA5);
      wr(IDX_PI3, 8'h00);
      run <= 1'b1;
      for (int b = 0; b < 16; b++) begin
        @(posedge txe);
        @(posedge aclk);
        #1;
        p = {p[14:0], tx_bit};
      end
      check(p[15:8], 8'hA5 ^ {8{i[0]}});
      check(p[7:0], 8'hA5 ^ {8{i[0]}});
    end
    $display("transmit done");
  endtask : t_tx

  task automatic t_sync;
    for (int m = 0; m < 2; m++) begin
      run <= 1'b0;
      wr(IDX_CTRL, {3'h0, m[0], 4'hE});
      wr(IDX_LEN, m == 0 ? 8'h06 : 8'h07);
      wr(IDX_TAP, 8'h05);
      for (int k = 0; k < 4; k++)
        wr(IDX_PI0 + 7'(k), m == 0 ? 8'hFF : (k == 0 ? 8'hA5 : 8'h00));
      wr(IDX_CTRL, {3'h0, m[0], 4'hF});
      run <= 1'b1;
      repeat (480) @(posedge aclk);
      rd(IDX_IRQ, v);
      check(v[4:3], 2'h3);
      rd(IDX_IRQ, v);
      check(v[3], 1'b0);
    end
    $display("sync done");
  endtask : t_sync

  task automatic t_err;
    wr(IDX_CTRL, 8'h9F);
    rd(IDX_IRQ, v);
    wr(IDX_GUPD, 8'h00);
    wr(IDX_EINS, 8'h08);
    repeat (80) @(posedge aclk);
    wr(IDX_EINS, 8'h00);
    wr(IDX_GUPD, 8'h00);
    rd(IDX_PD0, v);
    check(v, 8'h01);
    // One error per hundred bits; 250 bits hold exactly two
    wr(IDX_EINS, 8'h02);
    wr(IDX_GUPD, 8'h00);
    repeat (1000) @(posedge aclk);
    wr(IDX_GUPD, 8'h00);
    wr(IDX_EINS, 8'h00);
    rd(IDX_PD0, v);
    check(v, 8'h02);
    wr(IDX_GUPD, 8'h00);
    rd(IDX_IRQ, v);
    check(v, 8'h17);
    check(irq_n, 1'b1);
    wr(IDX_IRQ, 8'h20);
    wr(IDX_GUPD, 8'h00);
    repeat (2) @(posedge aclk);
    check(irq_n, 1'b0);
    rd(IDX_IRQ, v);
    repeat (2) @(posedge aclk);
    check(irq_n, 1'b1);
    wr(IDX_IRQ, 8'h00);
    wr(IDX_AUX, 8'h01);
    repeat (210) @(posedge aclk);
    rd(IDX_IRQ, v);
    check(v[1], 1'b1);
    wr(IDX_AUX, 8'h00);
    $display("errors done");
  endtask : t_err

  // Automatic search off, so the detector halts after loss
  task automatic t_loss;
    wr(IDX_CTRL, 8'h9D);
    flip <= 1'b1;
    repeat (80) @(posedge aclk);
    wr(IDX_GUPD, 8'h00);
    repeat (80) @(posedge aclk);
    wr(IDX_GUPD, 8'h00);
    rd(IDX_PD0, v);
    check(v, 8'h00);
    flip <= 1'b0;
    repeat (320) @(posedge aclk);
    rd(IDX_IRQ, v);
    check(v[4:2], 3'h3);
    wr(IDX_CTRL, 8'h9C);
    wr(IDX_CTRL, 8'h9D);
    repeat (480) @(posedge aclk);
    rd(IDX_IRQ, v);
    check(v[4], 1'b1);
    $display("loss done");
  endtask : t_loss

  task automatic t_func;
    for (int f = 0; f < 2; f++) begin
      wr(IDX_CTRL, {1'b0, f[0], 6'h1D});
      wr(IDX_GUPD, 8'h00);
      rd(IDX_PD0, v);
      check(8'(v inside {8'hA5, 8'h4B, 8'h96, 8'h2D, 8'h5A, 8'hB4,
        8'h69, 8'hD2}), 8'h01);
    end
    wr(IDX_CTRL, 8'hDD);
    wr(IDX_GUPD, 8'h00);
    repeat (256) @(posedge aclk);
    wr(IDX_GUPD, 8'h00);
    rd(IDX_PD0, v);
    check(8'(v >= 8'h3F && v <= 8'h44), 8'h01);
    $display("functions done");
  endtask : t_func

  task automatic end_sim;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Run takes about 4000 cycles; five times that means a hang
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    end_sim;
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_tx;
    t_sync;
    t_err;
    t_loss;
    t_func;
    end_sim;
  end
endmodule : test_pattern_gen_detect

`default_nettype wire
